// file: inc/fpl_pkg.sv
// Shared constants and types for the front-panel lamp controller
package fpl_pkg;

	// Avalon-MM slave geometry
	localparam int unsigned FPL_ADDR_W = 8;
	localparam int unsigned FPL_DATA_W = 32;
	localparam int unsigned FPL_BE_W   = 4;

	// Register byte offsets
	localparam logic [7:0] FPL_OFF_CTRL    = 8'h00;
	localparam logic [7:0] FPL_OFF_CODE    = 8'h04;
	localparam logic [7:0] FPL_OFF_USER    = 8'h08;
	localparam logic [7:0] FPL_OFF_HOTSWAP = 8'h0C;
	localparam logic [7:0] FPL_OFF_STATUS  = 8'h10;
	localparam logic [7:0] FPL_OFF_INTSTAT = 8'h14;
	localparam logic [7:0] FPL_OFF_INTMASK = 8'h18;

	// Control register fields
	localparam int unsigned FPL_CTRL_BOOT_BIT = 0;
	localparam int unsigned FPL_CTRL_SRC_LSB  = 1;
	localparam int unsigned FPL_SRC_W         = 2;

	// Interrupt bit positions; status uses the same layout except bit 0 (earlyFailure)
	localparam int unsigned FPL_EV_CODE  = 0;
	localparam int unsigned FPL_EV_NEAR  = 1;
	localparam int unsigned FPL_EV_ABOVE = 2;
	localparam int unsigned FPL_EV_TRIP  = 3;
	localparam int unsigned FPL_EV_WDOG  = 4;
	localparam int unsigned FPL_EV_W     = 5;

	// Reset values
	localparam logic [7:0]          FPL_RST_CODE = 8'h00;
	localparam logic [7:0]          FPL_RST_USER = 8'h00;
	localparam logic [FPL_EV_W-1:0] FPL_RST_MASK = 5'h00;

	// Host I/O address captured as the progress code
	localparam logic [15:0] FPL_PORT80_IO = 16'h0080;

	// Lamp pattern timing, times in ms at a 200 MHz clock
	localparam int unsigned FPL_CLK_HZ      = 200000000;
	localparam int unsigned FPL_FLICKER_MS  = 50;
	localparam int unsigned FPL_FLASH_MS    = 250;
	localparam int unsigned FPL_LONG_ON_MS  = 1500;
	localparam int unsigned FPL_LONG_OFF_MS = 500;
	localparam int unsigned FPL_CYC_PER_MS  = FPL_CLK_HZ / 1000;
	localparam int unsigned FPL_FLICKER_CYCLES  = FPL_FLICKER_MS * FPL_CYC_PER_MS;
	localparam int unsigned FPL_FLASH_CYCLES    = FPL_FLASH_MS * FPL_CYC_PER_MS;
	localparam int unsigned FPL_LONG_ON_CYCLES  = FPL_LONG_ON_MS * FPL_CYC_PER_MS;
	localparam int unsigned FPL_LONG_OFF_CYCLES = FPL_LONG_OFF_MS * FPL_CYC_PER_MS;

	// Source of the eight general lamps after boot
	typedef enum logic [FPL_SRC_W-1:0] {
		FPL_SRC_GENERAL,
		FPL_SRC_PORT80,
		FPL_SRC_BOARD
	} fpl_src_type;

endpackage : fpl_pkg

// file: verilog/fpl_blinker.sv
// Lamp pattern generator with separate on and off periods
`timescale 1ns/100ps

module fpl_blinker #(
	parameter int unsigned ON_CYCLES  = 4,
	parameter int unsigned OFF_CYCLES = 4
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic enable,
	output logic      lamp
);
	logic [31:0] count;
	logic [31:0] next_count;
	logic        next_lamp;

	if (ON_CYCLES < 1 || OFF_CYCLES < 1) begin : g_check
		$error("fpl_blinker: periods must be at least one cycle");
	end

	// Phase counter; disabled pattern restarts in the lit phase
	always_comb begin
		next_count = count + 32'h00000001;
		next_lamp  = lamp;
		if (!enable) begin
			next_count = 32'h00000000;
			next_lamp  = 1'b0;
		end else if (!lamp && count == 32'h00000000) begin
			next_lamp  = 1'b1; // First enabled cycle
			next_count = 32'h00000001;
		end else if (lamp && count >= ON_CYCLES) begin
			next_lamp  = 1'b0;
			next_count = 32'h00000001;
		end else if (!lamp && count >= OFF_CYCLES) begin
			next_lamp  = 1'b1;
			next_count = 32'h00000001;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= 32'h00000000;
			lamp  <= 1'b0;
		end else begin
			count <= next_count;
			lamp  <= next_lamp;
		end
	end

	property p_dark_when_off;
		@(posedge clk) disable iff (!rst_b) !enable |=> !lamp;
	endproperty
	a_dark_when_off: assert property (p_dark_when_off)
		else $error("blinker lit while disabled");

endmodule : fpl_blinker

// file: verilog/fpl_trip_latch.sv
// Thermal trip latch cleared only by power-on reset
`timescale 1ns/100ps

module fpl_trip_latch (
	input  wire logic clk,
	input  wire logic porRst_b,
	input  wire logic tripIn,
	output logic      tripLatched
);
	logic next_tripLatched;

	// Sticky set; a warm reset does not reach this flop
	always_comb begin
		next_tripLatched = tripLatched | tripIn;
	end

	always_ff @(posedge clk or negedge porRst_b) begin
		if (!porRst_b) begin
			tripLatched <= 1'b0;
		end else begin
			tripLatched <= next_tripLatched;
		end
	end

	property p_trip_holds;
		@(posedge clk) disable iff (!porRst_b) tripLatched |=> tripLatched;
	endproperty
	a_trip_holds: assert property (p_trip_holds)
		else $error("trip latch released without power cycle");

	property p_trip_sets;
		@(posedge clk) disable iff (!porRst_b) tripIn |=> tripLatched;
	endproperty
	a_trip_sets: assert property (p_trip_sets)
		else $error("trip input not latched");

endmodule : fpl_trip_latch

// file: verilog/fpl_front_panel.sv
// Front-panel lamp controller: register slave, lamp selection and interrupts
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/100ps

module fpl_front_panel
	import fpl_pkg::*;
#(
	parameter int unsigned FLICKER_CYCLES  = FPL_FLICKER_CYCLES,
	parameter int unsigned FLASH_CYCLES    = FPL_FLASH_CYCLES,
	parameter int unsigned LONG_ON_CYCLES  = FPL_LONG_ON_CYCLES,
	parameter int unsigned LONG_OFF_CYCLES = FPL_LONG_OFF_CYCLES
) (
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  porRst_b,
	input  wire logic [FPL_ADDR_W-1:0] address,
	input  wire logic                  read,
	input  wire logic                  write,
	input  wire logic [FPL_DATA_W-1:0] writedata,
	input  wire logic [FPL_BE_W-1:0]   byteenable,
	output logic      [FPL_DATA_W-1:0] readdata,
	output logic                       waitrequest,
	input  wire logic                  ioWrite,
	input  wire logic [15:0]           ioAddress,
	input  wire logic [7:0]            ioData,
	input  wire logic                  tempNear,
	input  wire logic                  tempAbove,
	input  wire logic                  thermTrip,
	input  wire logic                  earlyFailure,
	input  wire logic                  watchdogActive,
	input  wire logic                  diskPrimary,
	input  wire logic                  diskSecondary,
	input  wire logic                  diskSata,
	output logic      [3:0]            upperNibbleLamps,
	output logic      [3:0]            lowerNibbleLamps,
	output logic                       watchdogLamp,
	output logic                       heatAlarmLamp,
	output logic                       extractionReadyLamp,
	output logic                       irq
);
	// Register state
	logic                  bootDone;
	fpl_src_type           sourceSel;
	logic [7:0]            code;
	logic [7:0]            userLamps;
	logic [FPL_EV_W-1:0]   intStatus;
	logic [FPL_EV_W-1:0]   intMask;
	logic                  next_bootDone;
	fpl_src_type           next_sourceSel;
	logic [7:0]            next_code;
	logic [7:0]            next_userLamps;
	logic                  next_extractionReadyLamp;
	logic [FPL_EV_W-1:0]   next_intStatus;
	logic [FPL_EV_W-1:0]   next_intMask;
	logic                  next_irq;
	// Bus state
	logic [FPL_DATA_W-1:0] next_readdata;
	logic                  next_waitrequest;
	logic                  wrEn;
	// Event edge history
	logic                  nearPrev;
	logic                  abovePrev;
	logic                  tripPrev;
	logic                  wdogPrev;
	logic [FPL_EV_W-1:0]   events;
	logic                  codeWrite;
	// Lamp state
	logic [7:0]            next_lamps;
	logic                  next_watchdogLamp;
	logic                  next_heatAlarmLamp;
	logic                  tripLatched;
	logic                  flickerLamp;
	logic                  flashLamp;
	logic                  longLamp;
	logic                  flickerOn;
	logic                  flashOn;
	logic                  longOn;
	logic [FPL_EV_W-1:0]   statusBits;

	// Register select helper used by both read and write decode
	function automatic logic hit(input logic [FPL_ADDR_W-1:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// Latched trip survives warm reset
	fpl_trip_latch u_trip (
		.clk         (clk),
		.porRst_b    (porRst_b),
		.tripIn      (thermTrip),
		.tripLatched (tripLatched)
	);

	// Three pattern generators, each with its own period pair
	fpl_blinker #(.ON_CYCLES(FLICKER_CYCLES), .OFF_CYCLES(FLICKER_CYCLES)) u_flicker (
		.clk    (clk),
		.rst_b  (rst_b),
		.enable (flickerOn),
		.lamp   (flickerLamp)
	);
	fpl_blinker #(.ON_CYCLES(FLASH_CYCLES), .OFF_CYCLES(FLASH_CYCLES)) u_flash (
		.clk    (clk),
		.rst_b  (rst_b),
		.enable (flashOn),
		.lamp   (flashLamp)
	);
	fpl_blinker #(.ON_CYCLES(LONG_ON_CYCLES), .OFF_CYCLES(LONG_OFF_CYCLES)) u_long (
		.clk    (clk),
		.rst_b  (rst_b),
		.enable (longOn),
		.lamp   (longLamp)
	);

	// Pattern enables; a generator idles dark when its pattern is unused
	assign flashOn   = !bootDone && earlyFailure;
	assign longOn    = bootDone && tripLatched;
	assign flickerOn = bootDone && !tripLatched && !tempAbove && tempNear;

	// Live state visible to software
	assign statusBits = {watchdogActive, tripLatched, tempAbove, tempNear, earlyFailure};

	// Bus answer: one wait cycle, then completion with registered read data
	always_comb begin
		next_waitrequest = 1'b1;
		next_readdata    = '0;
		if ((read || write) && waitrequest) begin
			next_waitrequest = 1'b0;
			if (read) begin
				if (hit(address, FPL_OFF_CTRL)) begin
					next_readdata[FPL_CTRL_BOOT_BIT] = bootDone;
					next_readdata[FPL_CTRL_SRC_LSB +: FPL_SRC_W] = sourceSel;
				end else if (hit(address, FPL_OFF_CODE)) begin
					next_readdata[7:0] = code;
				end else if (hit(address, FPL_OFF_USER)) begin
					next_readdata[7:0] = userLamps;
				end else if (hit(address, FPL_OFF_HOTSWAP)) begin
					next_readdata[0] = extractionReadyLamp;
				end else if (hit(address, FPL_OFF_STATUS)) begin
					next_readdata[FPL_EV_W-1:0] = statusBits;
				end else if (hit(address, FPL_OFF_INTSTAT)) begin
					next_readdata[FPL_EV_W-1:0] = intStatus;
				end else if (hit(address, FPL_OFF_INTMASK)) begin
					next_readdata[FPL_EV_W-1:0] = intMask;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			waitrequest <= 1'b1;
			readdata    <= '0;
		end else begin
			waitrequest <= next_waitrequest;
			readdata    <= next_readdata;
		end
	end

	// Writes act at the completing edge; every field lives in byte lane 0
	assign wrEn = write && !waitrequest && byteenable[0];
	assign codeWrite = ioWrite && (ioAddress == FPL_PORT80_IO);

	// Event sources for the sticky status bits
	assign events[FPL_EV_CODE]  = codeWrite;
	assign events[FPL_EV_NEAR]  = tempNear && !nearPrev;
	assign events[FPL_EV_ABOVE] = tempAbove && !abovePrev;
	assign events[FPL_EV_TRIP]  = tripLatched && !tripPrev;
	assign events[FPL_EV_WDOG]  = watchdogActive && !wdogPrev;

	// Register updates; a hardware set beats a same-cycle software clear
	always_comb begin
		next_bootDone            = bootDone;
		next_sourceSel           = sourceSel;
		next_code                = code;
		next_userLamps           = userLamps;
		next_extractionReadyLamp = extractionReadyLamp;
		next_intMask             = intMask;
		next_intStatus           = intStatus;
		if (wrEn) begin
			if (hit(address, FPL_OFF_CTRL)) begin
				next_bootDone  = writedata[FPL_CTRL_BOOT_BIT];
				next_sourceSel = fpl_src_type'(writedata[FPL_CTRL_SRC_LSB +: FPL_SRC_W]);
			end else if (hit(address, FPL_OFF_USER)) begin
				next_userLamps = writedata[7:0];
			end else if (hit(address, FPL_OFF_HOTSWAP)) begin
				next_extractionReadyLamp = writedata[0];
			end else if (hit(address, FPL_OFF_INTSTAT)) begin
				next_intStatus = intStatus & ~writedata[FPL_EV_W-1:0];
			end else if (hit(address, FPL_OFF_INTMASK)) begin
				next_intMask = writedata[FPL_EV_W-1:0];
			end
		end
		if (codeWrite) begin
			next_code = ioData;
		end
		next_intStatus = next_intStatus | events;
		next_irq = |(intStatus & intMask);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bootDone            <= 1'b0;
			sourceSel           <= FPL_SRC_GENERAL;
			code                <= FPL_RST_CODE;
			userLamps           <= FPL_RST_USER;
			extractionReadyLamp <= 1'b0;
			intStatus           <= '0;
			intMask             <= FPL_RST_MASK;
			irq                 <= 1'b0;
			nearPrev            <= 1'b0;
			abovePrev           <= 1'b0;
			tripPrev            <= 1'b1; // No false trip event after a warm reset
			wdogPrev            <= 1'b0;
		end else begin
			bootDone            <= next_bootDone;
			sourceSel           <= next_sourceSel;
			code                <= next_code;
			userLamps           <= next_userLamps;
			extractionReadyLamp <= next_extractionReadyLamp;
			intStatus           <= next_intStatus;
			intMask             <= next_intMask;
			irq                 <= next_irq;
			nearPrev            <= tempNear;
			abovePrev           <= tempAbove;
			tripPrev            <= tripLatched;
			wdogPrev            <= watchdogActive;
		end
	end

	// Lamp selection; an unused source code falls back to general mode
	always_comb begin
		next_lamps = code;
		if (bootDone) begin
			case (sourceSel)
				FPL_SRC_PORT80: next_lamps = code;
				FPL_SRC_BOARD:  next_lamps = {5'h00, diskSata, diskSecondary, diskPrimary};
				default:        next_lamps = userLamps;
			endcase
		end
		// Thermal priority: shutdown over steady over flicker
		next_heatAlarmLamp = 1'b0;
		next_watchdogLamp  = 1'b0;
		if (!bootDone) begin
			next_heatAlarmLamp = flashLamp;
			next_watchdogLamp  = flashLamp;
		end else begin
			next_watchdogLamp = watchdogActive;
			if (tripLatched) begin
				next_heatAlarmLamp = longLamp;
			end else if (tempAbove) begin
				next_heatAlarmLamp = 1'b1;
			end else if (tempNear) begin
				next_heatAlarmLamp = flickerLamp;
			end
		end
	end

	// Lit lamp for a one bit; high nibble on the upper group
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			upperNibbleLamps <= 4'h0;
			lowerNibbleLamps <= 4'h0;
			watchdogLamp     <= 1'b0;
			heatAlarmLamp    <= 1'b0;
		end else begin
			upperNibbleLamps <= next_lamps[7:4];
			lowerNibbleLamps <= next_lamps[3:0];
			watchdogLamp     <= next_watchdogLamp;
			heatAlarmLamp    <= next_heatAlarmLamp;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	property p_boot_code;
		!bootDone |=> {upperNibbleLamps, lowerNibbleLamps} == $past(code);
	endproperty
	a_boot_code: assert property (p_boot_code)
		else $error("boot lamps differ from progress code");

	property p_port80_split;
		bootDone && sourceSel == FPL_SRC_PORT80
			|=> upperNibbleLamps == $past(code[7:4]) && lowerNibbleLamps == $past(code[3:0]);
	endproperty
	a_port80_split: assert property (p_port80_split)
		else $error("nibble groups swapped or stale");

	property p_general;
		bootDone && sourceSel == FPL_SRC_GENERAL
			|=> {upperNibbleLamps, lowerNibbleLamps} == $past(userLamps);
	endproperty
	a_general: assert property (p_general)
		else $error("general lamps not following software");

	property p_board;
		bootDone && sourceSel == FPL_SRC_BOARD
			|=> upperNibbleLamps == 4'h0 && lowerNibbleLamps[3] == 1'b0
			&& lowerNibbleLamps[2:0] == $past({diskSata, diskSecondary, diskPrimary});
	endproperty
	a_board: assert property (p_board)
		else $error("board-specific lamps wrong");

	property p_code_capture;
		codeWrite |=> code == $past(ioData)
			##1 (lowerNibbleLamps == $past(code[3:0]) || $past(bootDone));
	endproperty
	a_code_capture: assert property (p_code_capture)
		else $error("progress code not captured");

	property p_code_hold;
		!codeWrite |=> code == $past(code);
	endproperty
	a_code_hold: assert property (p_code_hold)
		else $error("progress code changed without a write");

	property p_steady_hot;
		bootDone && !tripLatched && tempAbove |=> heatAlarmLamp;
	endproperty
	a_steady_hot: assert property (p_steady_hot)
		else $error("heat lamp not steady above limit");

	property p_flicker;
		flickerOn |=> heatAlarmLamp == $past(flickerLamp);
	endproperty
	a_flicker: assert property (p_flicker)
		else $error("heat lamp not flickering");

	property p_long_blink;
		longOn |=> heatAlarmLamp == $past(longLamp);
	endproperty
	a_long_blink: assert property (p_long_blink)
		else $error("heat lamp not long-blinking after trip");

	property p_early_fail;
		!bootDone |=> watchdogLamp == heatAlarmLamp;
	endproperty
	a_early_fail: assert property (p_early_fail)
		else $error("boot failure lamps not flashing together");

	property p_hotswap;
		wrEn && hit(address, FPL_OFF_HOTSWAP) |=> extractionReadyLamp == $past(writedata[0]);
	endproperty
	a_hotswap: assert property (p_hotswap)
		else $error("extraction lamp ignores software");

	property p_irq;
		|(intStatus & intMask) |=> irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt not raised");

	property p_bus_answer;
		(read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus answer timing wrong");

	c_port80: cover property (bootDone && sourceSel == FPL_SRC_PORT80 && codeWrite);
	c_board: cover property (bootDone && sourceSel == FPL_SRC_BOARD && diskSata);
	c_trip: cover property (bootDone && $rose(tripLatched));
	c_early: cover property (!bootDone && $rose(flashLamp));

endmodule : fpl_front_panel

// file: bench/fpl_host_io.sv
// Host processor model issuing progress-code writes on the port I/O bus
`timescale 1ns/100ps

module fpl_host_io (
	input  wire logic        clk,
	output logic             ioWrite,
	output logic [15:0]      ioAddress,
	output logic [7:0]       ioData
);
	initial begin
		ioWrite   = 1'b0;
		ioAddress = 16'h0000;
		ioData    = 8'h00;
	end

	// One-cycle write strobe; address and data are scrambled once released,
	// so a device that samples them late sees garbage rather than a stale value
	task automatic ioPost(input logic [15:0] addr, input logic [7:0] data);
		ioWrite   <= 1'b1;
		ioAddress <= addr;
		ioData    <= data;
		@(posedge clk);
		ioWrite   <= 1'b0;
		ioAddress <= ~addr;
		ioData    <= ~data;
		@(posedge clk);
	endtask : ioPost
endmodule : fpl_host_io

// file: bench/fpl_front_panel_bench.sv
// Self-checking bench for the front-panel lamp controller
`timescale 1ns/100ps

module fpl_front_panel_bench;
	import fpl_pkg::*;

	logic                  clk, rst_b, porRst_b, read, write, waitrequest, irq;
	logic [FPL_ADDR_W-1:0] address;
	logic [FPL_DATA_W-1:0] writedata, readdata, rd;
	logic [FPL_BE_W-1:0]   byteenable;
	logic                  ioWrite, tempNear, tempAbove, thermTrip, earlyFailure;
	logic                  watchdogActive, diskPrimary, diskSecondary, diskSata;
	logic [15:0]           ioAddress;
	logic [7:0]            ioData;
	logic [3:0]            upperNibbleLamps, lowerNibbleLamps;
	logic                  watchdogLamp, heatAlarmLamp, extractionReadyLamp;
	int                    failures, comparisons, litCount;

	fpl_front_panel #(.FLICKER_CYCLES(2), .FLASH_CYCLES(4), .LONG_ON_CYCLES(8),
		.LONG_OFF_CYCLES(3)) i_fpl_front_panel (
		.clk(clk), .rst_b(rst_b), .porRst_b(porRst_b), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .ioWrite(ioWrite),
		.ioAddress(ioAddress), .ioData(ioData), .tempNear(tempNear),
		.tempAbove(tempAbove), .thermTrip(thermTrip), .earlyFailure(earlyFailure),
		.watchdogActive(watchdogActive), .diskPrimary(diskPrimary),
		.diskSecondary(diskSecondary), .diskSata(diskSata),
		.upperNibbleLamps(upperNibbleLamps), .lowerNibbleLamps(lowerNibbleLamps),
		.watchdogLamp(watchdogLamp), .heatAlarmLamp(heatAlarmLamp),
		.extractionReadyLamp(extractionReadyLamp), .irq(irq));

	fpl_host_io i_fpl_host_io (.clk(clk), .ioWrite(ioWrite), .ioAddress(ioAddress),
		.ioData(ioData));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	// Value comparison, mismatches reported with time and both values
	task automatic check(input logic [31:0] seen, input logic [31:0] expected);
		comparisons++;
		if (seen !== expected) begin
			failures++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask : check

	// Avalon write: request held until waitrequest is sampled low
	task automatic busWrite(input logic [7:0] addr, input logic [31:0] data,
		input logic [3:0] be = 4'hF);
		write <= 1'b1;
		address <= addr;
		writedata <= data;
		byteenable <= be;
		// No cycle count assumed; only the bench watchdog ends a stuck wait
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		write <= 1'b0;
		@(posedge clk);
	endtask : busWrite

	// Avalon read: data taken at the edge where waitrequest is low
	task automatic busRead(input logic [7:0] addr, output logic [31:0] data);
		read <= 1'b1;
		address <= addr;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		data = readdata;
		read <= 1'b0;
		@(posedge clk);
	endtask : busRead

	task automatic readCheck(input logic [7:0] addr, input logic [31:0] expected);
		busRead(addr, rd);
		check(rd, expected);
	endtask : readCheck

	// Lets the lamp registers follow a change before they are looked at
	task automatic settle();
		repeat (4) @(posedge clk);
	endtask : settle

	// Counts lit cycles of the heat lamp (0) or watchdog lamp (1)
	task automatic countLit(input int sel, input int n, output int lit);
		lit = 0;
		repeat (n) begin
			@(posedge clk);
			lit += ((sel == 0 ? heatAlarmLamp : watchdogLamp) === 1'b1) ? 1 : 0;
		end
	endtask : countLit

	task automatic complete_run();
		$display("Comparisons %0d, failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	// Whole run needs about five hundred cycles; this bound only cuts a hang
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		complete_run();
	end

	initial begin
		clk = 1'b0; rst_b = 1'b0; porRst_b = 1'b0; read = 1'b0; write = 1'b0;
		address = 8'h00; writedata = 32'h0; byteenable = 4'h0;
		tempNear = 1'b0; tempAbove = 1'b0; thermTrip = 1'b0; earlyFailure = 1'b0;
		watchdogActive = 1'b0; diskPrimary = 1'b0; diskSecondary = 1'b0; diskSata = 1'b0;
		failures = 0; comparisons = 0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		porRst_b <= 1'b1;
		@(posedge clk);
		// Reset values, unmapped and ignored writes
		check({upperNibbleLamps, lowerNibbleLamps}, 32'h0);
		readCheck(FPL_OFF_CTRL, 32'h0);
		readCheck(FPL_OFF_INTMASK, 32'h0);
		busWrite(8'h1C, 32'hFF);
		readCheck(8'h1C, 32'h0);
		busWrite(FPL_OFF_USER, 32'h5A, 4'hE);
		readCheck(FPL_OFF_USER, 32'h0);
		$display("Test reset and refusals done");
		// Boot: progress code captured only at its I/O address
		i_fpl_host_io.ioPost(FPL_PORT80_IO, 8'hA5);
		i_fpl_host_io.ioPost(16'h0081, 8'h3C);
		settle();
		check({upperNibbleLamps, lowerNibbleLamps}, 32'hA5);
		readCheck(FPL_OFF_CODE, 32'hA5);
		i_fpl_host_io.ioPost(FPL_PORT80_IO, 8'h81);
		i_fpl_host_io.ioPost(FPL_PORT80_IO, 8'h7E);
		settle();
		check({upperNibbleLamps, lowerNibbleLamps}, 32'h7E);
		// Early failure flashes both lamps together
		earlyFailure <= 1'b1;
		settle();
		countLit(0, 40, litCount);
		check(litCount, 20);
		countLit(1, 40, litCount);
		check(litCount, 20);
		earlyFailure <= 1'b0;
		$display("Test boot done");
		// After boot: general default, then each source
		busWrite(FPL_OFF_CTRL, 32'h1);
		settle();
		check({upperNibbleLamps, lowerNibbleLamps}, 32'h0);
		busWrite(FPL_OFF_USER, 32'hC3);
		settle();
		check({upperNibbleLamps, lowerNibbleLamps}, 32'hC3);
		busWrite(FPL_OFF_CTRL, 32'h3);
		settle();
		check({upperNibbleLamps, lowerNibbleLamps}, 32'h7E);
		busWrite(FPL_OFF_CTRL, 32'h5);
		for (int i = 0; i < 8; i++) begin
			diskPrimary <= i[0];
			diskSecondary <= i[1];
			diskSata <= i[2];
			settle();
			check({upperNibbleLamps, lowerNibbleLamps}, i);
		end
		// Unused source code falls back to the software-driven lamps
		busWrite(FPL_OFF_CTRL, 32'h7);
		settle();
		check({upperNibbleLamps, lowerNibbleLamps}, 32'hC3);
		busWrite(FPL_OFF_CTRL, 32'h1);
		settle();
		check({upperNibbleLamps, lowerNibbleLamps}, 32'hC3);
		$display("Test lamp sources done");
		// Extraction lamp and watchdog status
		busWrite(FPL_OFF_HOTSWAP, 32'h1);
		settle();
		check(extractionReadyLamp, 1'b1);
		busWrite(FPL_OFF_HOTSWAP, 32'h0);
		settle();
		check(extractionReadyLamp, 1'b0);
		watchdogActive <= 1'b1;
		settle();
		countLit(1, 20, litCount);
		check(litCount, 20);
		watchdogActive <= 1'b0;
		// Heat lamp: flicker, steady, long blink
		tempNear <= 1'b1;
		settle();
		countLit(0, 40, litCount);
		check(litCount, 20);
		tempAbove <= 1'b1;
		settle();
		countLit(0, 20, litCount);
		check(litCount, 20);
		tempNear <= 1'b0;
		tempAbove <= 1'b0;
		thermTrip <= 1'b1;
		@(posedge clk);
		thermTrip <= 1'b0;
		settle();
		countLit(0, 44, litCount);
		check(litCount, 32);
		// Warm reset keeps the trip, power-on reset clears it
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		readCheck(FPL_OFF_STATUS, 32'h8);
		busWrite(FPL_OFF_CTRL, 32'h1);
		settle();
		countLit(0, 44, litCount);
		check(litCount, 32);
		porRst_b <= 1'b0;
		@(posedge clk);
		porRst_b <= 1'b1;
		@(posedge clk);
		readCheck(FPL_OFF_STATUS, 32'h0);
		$display("Test heat and trip done");
		// Interrupt: set, masked, cleared by writing one
		busWrite(FPL_OFF_INTSTAT, 32'h1F);
		readCheck(FPL_OFF_INTSTAT, 32'h0);
		busWrite(FPL_OFF_INTMASK, 32'h1);
		i_fpl_host_io.ioPost(FPL_PORT80_IO, 8'h42);
		settle();
		check(irq, 1'b1);
		readCheck(FPL_OFF_INTSTAT, 32'h1);
		readCheck(FPL_OFF_CODE, 32'h42);
		busWrite(FPL_OFF_INTMASK, 32'h0);
		settle();
		check(irq, 1'b0);
		busWrite(FPL_OFF_INTMASK, 32'h1);
		busWrite(FPL_OFF_INTSTAT, 32'h1);
		settle();
		check(irq, 1'b0);
		readCheck(FPL_OFF_INTSTAT, 32'h0);
		$display("Test interrupt done");
		complete_run();
	end
endmodule : fpl_front_panel_bench
